// ---- pkg/macsec_fmt_pkg.sv ----
// Constants and types for the MACsec frame-format and classification stage.
// Assumes one 100 MHz clock domain and byte-wide frame streams.
`default_nettype none

package macsec_fmt_pkg;

  // ----------------------------------------------------------------
  // Frame layout, in bytes from the destination address
  // ----------------------------------------------------------------
  localparam logic [5:0] DA_END        = 6'h06; // Source address starts here
  localparam logic [5:0] SA_END        = 6'h0c; // Tags, labels or Ethertype start here
  localparam logic [5:0] TAG_BYTES     = 6'h04; // One VLAN tag: TPID plus TCI/VID
  localparam logic [5:0] LABEL_BYTES   = 6'h04; // One 32-bit MPLS label
  localparam logic [5:0] ETYPE_BYTES   = 6'h02;
  localparam logic [5:0] SECTAG_BYTES  = 6'h10;
  localparam logic [5:0] ICV_BYTES     = 6'h10;
  localparam logic [5:0] HDR_WIN       = 6'h28; // Classifiable header window
  localparam logic [5:0] POS_MAX       = 6'h3f;
  localparam logic [7:0] SECTAG_ET_HI  = 8'h88;
  localparam logic [7:0] SECTAG_ET_LO  = 8'he5;

  // ----------------------------------------------------------------
  // Security association table and pause thresholds
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SA    = 4;
  localparam int unsigned FLD_W     = 6; // One select bit per field code
  localparam logic [7:0]  FC_ON     = 8'h18; // Owed bytes that raise pause
  localparam logic [7:0]  FC_OFF    = 8'h08; // Owed bytes that release pause
  localparam logic [7:0]  FC_MAX    = 8'hff;

  // Frame format modes
  typedef enum logic [2:0] {
    MODE_STD   = 3'h0,
    MODE_BYP1  = 3'h1,
    MODE_BYP2  = 3'h2,
    MODE_MPLS1 = 3'h3,
    MODE_MPLS2 = 3'h4
  } mode_t;

  // Header field codes; F_T1/F_T2 also name MPLS labels 1/2
  typedef enum logic [2:0] {
    F_DA   = 3'h0,
    F_SA   = 3'h1,
    F_T1   = 3'h2,
    F_T2   = 3'h3,
    F_ET   = 3'h4,
    F_ST   = 3'h5,
    F_NONE = 3'h6
  } fld_t;

endpackage : macsec_fmt_pkg

`default_nettype wire

// ---- design/macsec_frame_format_classify.sv ----
// MACsec frame-format stage: SecTAG insertion, ICV slot, header classification, pause.
// Assumes host and line MACs on the same clock, frames starting at the DA, FCS removed.
`default_nettype none

module macsec_frame_format_classify (
  input  wire logic                  clock,      // 100 MHz
  input  wire logic                  rst_n,      // Synchronous reset
  input  wire logic                  ce,         // Freezes all state when low
  input  wire logic                  rxDir,      // 1: ingress, pre-decrypt
  input  wire macsec_fmt_pkg::mode_t mode,       // Frame format mode
  input  wire logic [1:0]            tagCount,   // VLAN tags seen by tag parser
  input  wire logic                  cfgWe,      // Write one pattern byte
  input  wire logic [1:0]            cfgSa,      // SA entry addressed
  input  wire logic [5:0]            cfgIdx,     // Pattern byte position
  input  wire logic [7:0]            cfgByte,    // Pattern byte value
  input  wire logic                  cfgMaskWe,  // Write field select of cfgSa
  input  wire logic [5:0]            cfgMask,    // Field select, bit per code
  input  wire logic [7:0]            secTci,     // TCI byte for inserted SecTAG
  input  wire logic [7:0]            hostData,   // Frame byte in
  input  wire logic                  hostValid,  // Byte valid
  input  wire logic                  hostFirst,  // First byte (DA)
  input  wire logic                  hostLast,   // Last byte
  output var  logic                  hostReady,  // Byte taken when high
  output var  logic [7:0]            lineData,   // Frame byte out
  output var  logic                  lineValid,  // Byte valid
  output var  logic                  lineLast,   // Last byte of frame
  output var  logic [3:0]            saHit,      // Entries matched
  output var  logic                  saHitValid, // One-cycle result strobe
  output var  logic                  pauseReq    // Pause toward system
);

  typedef enum logic [3:0] {
    S_HDR  = 4'b0001,
    S_TAG  = 4'b0010,
    S_BODY = 4'b0100,
    S_ICV  = 4'b1000
  } state_t;

  typedef struct packed {
    state_t                                 st;
    logic [5:0]                             pos;
    logic [5:0]                             cnt;
    logic                                   endSeen;
    logic                                   hdrDone;
    logic [3:0]                             live;
    logic [macsec_fmt_pkg::NUM_SA-1:0][39:0][7:0] pat;
    logic [macsec_fmt_pkg::NUM_SA-1:0][5:0] sel;
    logic [7:0]                             fc;
    logic                                   hostReady;
    logic [7:0]                             lineData;
    logic                                   lineValid;
    logic                                   lineLast;
    logic [3:0]                             saHit;
    logic                                   saHitValid;
    logic                                   pauseReq;
  } regs_t;

  regs_t r_reg;
  regs_t r_next;

  // ----------------------------------------------------------------
  // Header geometry
  // ----------------------------------------------------------------
  // Bytes kept in clear between source address and SecTAG
  function automatic logic [5:0] bypassLen(input macsec_fmt_pkg::mode_t m);
    case (m)
      macsec_fmt_pkg::MODE_BYP1:  bypassLen = macsec_fmt_pkg::TAG_BYTES;
      macsec_fmt_pkg::MODE_BYP2:  bypassLen = 6'(2 * macsec_fmt_pkg::TAG_BYTES);
      macsec_fmt_pkg::MODE_MPLS1:
        bypassLen = 6'(macsec_fmt_pkg::ETYPE_BYTES + macsec_fmt_pkg::LABEL_BYTES);
      macsec_fmt_pkg::MODE_MPLS2:
        bypassLen = 6'(macsec_fmt_pkg::ETYPE_BYTES + 2 * macsec_fmt_pkg::LABEL_BYTES);
      default:                    bypassLen = 6'h00;
    endcase
  endfunction : bypassLen

  // Which classifiable field a byte position belongs to
  function automatic macsec_fmt_pkg::fld_t fieldOf(input logic [5:0] p,
      input macsec_fmt_pkg::mode_t m, input logic [1:0] tags, input logic rx);
    logic [5:0] q;
    logic [5:0] b;
    logic [5:0] tb;
    logic       mpls;
    q    = p - macsec_fmt_pkg::SA_END;
    b    = bypassLen(m);
    tb   = {2'b00, tags, 2'b00};
    mpls = (m == macsec_fmt_pkg::MODE_MPLS1) || (m == macsec_fmt_pkg::MODE_MPLS2);
    fieldOf = macsec_fmt_pkg::F_NONE;
    if (p < macsec_fmt_pkg::DA_END) begin
      fieldOf = macsec_fmt_pkg::F_DA;
    end else if (p < macsec_fmt_pkg::SA_END) begin
      fieldOf = macsec_fmt_pkg::F_SA;
    end else if (mpls && (!rx || q < b)) begin
      // Ethertype and labels stay clear in both directions
      if (q < macsec_fmt_pkg::ETYPE_BYTES) begin
        fieldOf = macsec_fmt_pkg::F_ET;
      end else if (q < macsec_fmt_pkg::ETYPE_BYTES + macsec_fmt_pkg::LABEL_BYTES) begin
        fieldOf = macsec_fmt_pkg::F_T1;
      end else if (m == macsec_fmt_pkg::MODE_MPLS2 && q < 6'(macsec_fmt_pkg::ETYPE_BYTES
                   + 2 * macsec_fmt_pkg::LABEL_BYTES)) begin
        fieldOf = macsec_fmt_pkg::F_T2;
      end
    end else if (!rx) begin
      // Transmit sees the plain header, tags and Ethertype
      if (q < tb) begin
        fieldOf = (q < macsec_fmt_pkg::TAG_BYTES) ? macsec_fmt_pkg::F_T1
                                                  : macsec_fmt_pkg::F_T2;
      end else if (q < tb + macsec_fmt_pkg::ETYPE_BYTES) begin
        fieldOf = macsec_fmt_pkg::F_ET;
      end
    end else if (q < b) begin
      // Only bypassed tags precede the SecTAG on receive
      fieldOf = (q < macsec_fmt_pkg::TAG_BYTES) ? macsec_fmt_pkg::F_T1
                                                : macsec_fmt_pkg::F_T2;
    end else if (q < b + macsec_fmt_pkg::SECTAG_BYTES) begin
      fieldOf = macsec_fmt_pkg::F_ST; // Everything later is ciphertext
    end
  endfunction : fieldOf

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic                 take;
  logic [5:0]           p;
  logic [5:0]           insAt;
  macsec_fmt_pkg::fld_t fld;

  assign take  = hostValid && r_reg.hostReady;
  assign p     = hostFirst ? 6'h00 : r_reg.pos; // Position 0 is the DA
  // Cast keeps the sum at position width; the largest insertion point is 22
  assign insAt = 6'(macsec_fmt_pkg::SA_END + bypassLen(mode));
  assign fld   = fieldOf(p, mode, tagCount, rxDir);

  // One pass of the stream: classify, forward, insert, count expansion
  always_comb begin
    r_next            = r_reg;
    r_next.lineValid  = 1'b0;
    r_next.lineLast   = 1'b0;
    r_next.saHitValid = 1'b0;
    if (cfgWe) begin
      r_next.pat[cfgSa][cfgIdx] = cfgByte;
    end
    if (cfgMaskWe) begin
      r_next.sel[cfgSa] = cfgMask; // Fields chosen per entry
    end
    case (r_reg.st)
      S_HDR, S_BODY: begin
        if (take) begin
          // Frames of every kind, timing ones too, take the same path
          r_next.lineData  = hostData; // Host side in, line side out
          r_next.lineValid = 1'b1;
          r_next.lineLast  = hostLast && rxDir;
          r_next.pos       = (p == macsec_fmt_pkg::POS_MAX) ? p : p + 6'h01;
          if (hostFirst) begin
            r_next.live    = 4'hf;
            r_next.hdrDone = 1'b0;
          end
          if ((hostFirst || !r_reg.hdrDone) && p < macsec_fmt_pkg::HDR_WIN) begin
            for (int s = 0; s < macsec_fmt_pkg::NUM_SA; s++) begin
              if (fld != macsec_fmt_pkg::F_NONE && r_reg.sel[s][fld] &&
                  hostData != r_reg.pat[s][p]) begin
                r_next.live[s] = 1'b0; // Selected field differs
              end
            end
            if (hostLast || p == macsec_fmt_pkg::HDR_WIN - 6'h01) begin
              r_next.hdrDone    = 1'b1;
              r_next.saHit      = r_next.live;
              r_next.saHitValid = 1'b1;
            end
          end
          if (!rxDir && r_reg.st == S_HDR && (hostLast || p == insAt - 6'h01)) begin
            r_next.st      = S_TAG; // SecTAG follows bypassed header
            r_next.cnt     = 6'h00;
            r_next.endSeen = hostLast;
          end else if (!rxDir && hostLast) begin
            r_next.st  = S_ICV;
            r_next.cnt = 6'h00;
          end
        end
      end
      S_TAG: begin
        r_next.lineValid = 1'b1;
        case (r_reg.cnt)
          6'h00:   r_next.lineData = macsec_fmt_pkg::SECTAG_ET_HI;
          6'h01:   r_next.lineData = macsec_fmt_pkg::SECTAG_ET_LO;
          6'h02:   r_next.lineData = secTci;
          default: r_next.lineData = 8'h00;
        endcase
        r_next.cnt = r_reg.cnt + 6'h01;
        if (r_reg.cnt == macsec_fmt_pkg::SECTAG_BYTES - 6'h01) begin
          r_next.st  = r_reg.endSeen ? S_ICV : S_BODY;
          r_next.cnt = 6'h00;
        end
      end
      S_ICV: begin
        // Slot for the check value, filled by the crypto transform
        r_next.lineValid = 1'b1;
        r_next.lineData  = 8'h00;
        r_next.cnt       = r_reg.cnt + 6'h01;
        if (r_reg.cnt == macsec_fmt_pkg::ICV_BYTES - 6'h01) begin
          r_next.lineLast = 1'b1;
          r_next.st       = S_HDR;
          r_next.pos      = 6'h00;
        end
      end
      default: r_next.st = S_HDR;
    endcase
    // Input stalls while inserted bytes go out; the host sees the hold
    r_next.hostReady = (r_next.st == S_HDR) || (r_next.st == S_BODY);
    // Inserted bytes are owed to the line; idle line cycles repay them
    if ((r_reg.st == S_TAG || r_reg.st == S_ICV) && r_reg.fc != macsec_fmt_pkg::FC_MAX) begin
      r_next.fc = r_reg.fc + 8'h01;
    end else if (!r_next.lineValid && r_reg.fc != 8'h00) begin
      r_next.fc = r_reg.fc - 8'h01;
    end
    // Hysteresis keeps the pause request from chattering
    if (r_next.fc >= macsec_fmt_pkg::FC_ON) begin
      r_next.pauseReq = 1'b1;
    end else if (r_next.fc <= macsec_fmt_pkg::FC_OFF) begin
      r_next.pauseReq = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Whole state in one register; clock enable freezes everything
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r_reg    <= '0;
      r_reg.st <= S_HDR;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the register
  assign hostReady  = r_reg.hostReady;
  assign lineData   = r_reg.lineData;
  assign lineValid  = r_reg.lineValid;
  assign lineLast   = r_reg.lineLast;
  assign saHit      = r_reg.saHit;
  assign saHitValid = r_reg.saHitValid;
  assign pauseReq   = r_reg.pauseReq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n || !ce);

  sequence tagStart;
    r_reg.st == S_TAG && r_reg.cnt == 6'h00;
  endsequence
  sequence tagEtype;
    lineValid && lineData == macsec_fmt_pkg::SECTAG_ET_HI ##1
    lineValid && lineData == macsec_fmt_pkg::SECTAG_ET_LO;
  endsequence

  AST_TAG_ETYPE: assert property (tagStart |=> tagEtype)
    else $error("SecTAG Ethertype not emitted");
  AST_ICV_LEN: assert property ($rose(r_reg.st == S_ICV) |-> ##16 lineLast)
    else $error("ICV slot length wrong");
  AST_TAG_STALL: assert property (r_reg.st == S_TAG |-> !hostReady)
    else $error("Input taken during SecTAG insertion");
  AST_PASS: assert property (take |=> lineValid && lineData == $past(hostData))
    else $error("Host byte not forwarded to line");
  AST_PAUSE_ON: assert property (r_reg.fc >= macsec_fmt_pkg::FC_ON |-> pauseReq)
    else $error("Pause not raised at threshold");
  AST_PAUSE_OFF: assert property (r_reg.fc <= macsec_fmt_pkg::FC_OFF |-> !pauseReq)
    else $error("Pause held below release level");
  AST_RX_NO_TAG: assert property (rxDir && r_reg.st == S_HDR |=> r_reg.st != S_TAG)
    else $error("SecTAG inserted on receive");
  AST_CLS_MISS: assert property (take && (hostFirst || !r_reg.hdrDone)
      && p < macsec_fmt_pkg::HDR_WIN && fld != macsec_fmt_pkg::F_NONE
      && r_reg.sel[0][fld] && hostData != r_reg.pat[0][p] |=> !r_reg.live[0])
    else $error("Mismatch did not drop entry 0");
  // Receive keeps the frame boundary: the last byte goes out marked at once
  AST_RX_LAST: assert property (rxDir && take && hostLast |=> lineValid && lineLast)
    else $error("Receive frame end not forwarded");
  AST_ICV_STALL: assert property (r_reg.st == S_ICV |-> !hostReady)
    else $error("Input taken during ICV slot");

endmodule : macsec_frame_format_classify

`default_nettype wire

// ---- test/host_mac_model.sv ----
// Host-side MAC model: feeds one frame as a byte stream into the stage.
// Assumes the stage's registered hostReady and one shared 100 MHz clock.
`default_nettype none

module host_mac_model (
  input  wire logic       clock,     // Shared clock
  input  wire logic       hostReady, // Stage takes the byte
  output var  logic [7:0] hostData,  // Frame byte
  output var  logic       hostValid, // Byte valid
  output var  logic       hostFirst, // DA byte
  output var  logic       hostLast   // Final byte, FCS already gone
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] frm [0:79]; // Frame image loaded by the bench

  initial begin
    hostData  = 8'h00;
    hostValid = 1'b0;
    hostFirst = 1'b0;
    hostLast  = 1'b0;
  end

  // Frame starts at the DA, no preamble and no FCS; each byte held until taken
  // A nonzero gap releases the line between bytes to act as a slow sender
  task automatic send(input int len, input int gap);
    for (int i = 0; i < len; i++) begin
      hostData  <= frm[i];
      hostValid <= 1'b1;
      hostFirst <= (i == 0);
      hostLast  <= (i == len - 1);
      @(posedge clock);
      while (hostReady !== 1'b1) @(posedge clock);
      if (gap > 0 || i == len - 1) begin
        // Released line shows the inverse so a stale byte never passes for data
        hostValid <= 1'b0;
        hostFirst <= 1'b0;
        hostLast  <= 1'b0;
        hostData  <= ~frm[i];
        repeat (gap) @(posedge clock);
      end
    end
  endtask : send
endmodule : host_mac_model

`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the MACsec frame-format stage.
// Assumes the design package, the design and the host MAC model compile first.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] d; // Byte
    logic       l; // Last of frame
    logic       i; // Inserted by the stage
  } exp_t;

  logic                  clock, rst_n, rxDir, cfgWe, cfgMaskWe, ce;
  logic                  cePrev = 1'b1; // Enable as the design saw it at the last edge
  macsec_fmt_pkg::mode_t mode;
  logic [1:0]            tagCount, cfgSa;
  logic [5:0]            cfgIdx, cfgMask;
  logic [7:0]            cfgByte, secTci, hostData, lineData;
  logic                  hostValid, hostFirst, hostLast, hostReady;
  logic                  lineValid, lineLast, saHitValid, pauseReq;
  logic [3:0]            saHit;
  exp_t                  lq [$];
  logic [3:0]            hq [$];
  int                    n_fail, comparisons, cycles, fc;
  // Test table: mode, direction, tag count, length
  int tm [14] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 0, 2};
  int tr [14] = '{0, 0, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1};
  int tt [14] = '{0, 1, 2, 0, 1, 0, 2, 0, 0, 0, 0, 0, 0, 0};
  int tl [14] = '{60, 64, 64, 50, 48, 48, 70, 60, 50, 50, 50, 60, 8, 20};

  macsec_frame_format_classify dut (
    .clock(clock), .rst_n(rst_n), .ce(ce), .rxDir(rxDir), .mode(mode),
    .tagCount(tagCount), .cfgWe(cfgWe), .cfgSa(cfgSa), .cfgIdx(cfgIdx), .cfgByte(cfgByte),
    .cfgMaskWe(cfgMaskWe), .cfgMask(cfgMask), .secTci(secTci), .hostData(hostData),
    .hostValid(hostValid), .hostFirst(hostFirst), .hostLast(hostLast), .hostReady(hostReady),
    .lineData(lineData), .lineValid(lineValid), .lineLast(lineLast), .saHit(saHit),
    .saHitValid(saHitValid), .pauseReq(pauseReq));

  host_mac_model host (
    .clock(clock), .hostReady(hostReady), .hostData(hostData), .hostValid(hostValid),
    .hostFirst(hostFirst), .hostLast(hostLast));

  always #5 clock = ~clock;

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_sim();
    $display("counts: comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // Field code at byte position p: 0 DA, 1 SA, 2 tag1/label1, 3 tag2/label2, 4 Etype, 5 SecTAG
  function automatic int fld(input int p, input int m, input logic rx, input int tags);
    int b;
    if (p < 6) return 0;
    if (p < 12) return 1;
    if (m >= 3) begin
      b = (m == 4) ? 22 : 18;
      if (p < 14) return 4;
      if (p < 18) return 2;
      if (p < b) return 3;
      return (rx && p < b + 16) ? 5 : 6;
    end
    b = 12 + 4 * (rx ? m : tags);
    if (p < b) return (p < 16) ? 2 : 3;
    if (rx) return (p < b + 16) ? 5 : 6;
    return (p < b + 2) ? 4 : 6;
  endfunction : fld

  task automatic push(input logic [7:0] d, input logic l, input logic i);
    lq.push_back('{d: d, l: l, i: i});
  endtask : push

  task automatic pushTag(input logic [7:0] tci);
    for (int k = 0; k < 16; k++)
      push(k == 0 ? macsec_fmt_pkg::SECTAG_ET_HI : k == 1 ? macsec_fmt_pkg::SECTAG_ET_LO :
           k == 2 ? tci : 8'h00, 1'b0, 1'b1);
  endtask : pushTag

  // One frame: each entry gets a random field select and a pattern wrong at one position when that position falls below 40
  task automatic run(input int m, input logic rx, input int tags, input int len);
    int         ip, p, f;
    logic [5:0] msk;
    logic [3:0] hit;
    logic [7:0] tci;
    logic       held;
    ip  = 12 + ((m == 3) ? 6 : (m == 4) ? 10 : 4 * m);
    tci = 8'($urandom);
    for (int i = 0; i < 80; i++) host.frm[i] = 8'($urandom);
    @(posedge clock);
    mode     <= macsec_fmt_pkg::mode_t'(3'(m));
    rxDir    <= rx;
    tagCount <= 2'(tags);
    secTci   <= tci;
    for (int s = 0; s < 4; s++) begin
      p = $urandom_range(47, 0);
      msk = 6'($urandom);
      f = fld(p, m, rx, tags);
      hit[s] = !(p < len && p < 40 && f < 6 && msk[f]);
      cfgMaskWe <= 1'b1;
      cfgSa     <= 2'(s);
      cfgMask   <= msk;
      @(posedge clock);
      cfgMaskWe <= 1'b0;
      for (int i = 0; i < 40; i++) begin
        cfgWe   <= 1'b1;
        cfgIdx  <= 6'(i);
        cfgByte <= host.frm[i] ^ ((i == p) ? 8'h5a : 8'h00);
        @(posedge clock);
      end
      cfgWe <= 1'b0;
    end
    hq.push_back(hit);
    for (int i = 0; i < len; i++) begin
      if (!rx && i == ip) pushTag(tci);
      push(host.frm[i], rx && i == len - 1, 1'b0);
    end
    if (!rx) begin
      if (len <= ip) pushTag(tci);
      for (int k = 0; k < 16; k++) push(8'h00, k == 15, 1'b1);
    end
    host.send(len, $urandom_range(2, 0));
    for (int w = 0; w < 300 && (lq.size() + hq.size()) > 0; w++) @(posedge clock);
    check("results left over", 8'h00, 8'(lq.size() + hq.size()));
    // Idle freeze: with the enable low nothing may move, pause level included
    ce <= 1'b0;
    @(posedge clock);
    held = pauseReq;
    repeat (3) @(posedge clock);
    check("ce freeze pauseReq", {7'h00, held}, {7'h00, pauseReq});
    check("ce freeze hostReady", 8'h01, {7'h00, hostReady});
    ce <= 1'b1;
  endtask : run

  // Output watcher: pops the oldest note for each line byte and each classification
  always @(posedge clock) begin : watch
    exp_t       e;
    logic [3:0] hx;
    // A frozen edge leaves outputs standing; they are counted only once
    if (rst_n === 1'b1 && cePrev === 1'b1) begin
      if (lineValid === 1'b1) begin
        if (lq.size() == 0) begin
          check("lineValid", 8'h00, 8'h01);
        end else begin
          e = lq.pop_front();
          check("lineData", e.d, lineData);
          check("lineLast", {7'h00, e.l}, {7'h00, lineLast});
          if (e.i && fc < 255) fc++;
        end
      end else if (fc > 0) begin
        fc--;
      end
      if (saHitValid === 1'b1) begin
        hx = hq.size() ? hq.pop_front() : 4'hx;
        check("saHit", {4'h0, hx}, {4'h0, saHit});
      end
      if (fc >= macsec_fmt_pkg::FC_ON) check("pauseReq", 8'h01, {7'h00, pauseReq});
      if (fc <= macsec_fmt_pkg::FC_OFF) check("pauseReq", 8'h00, {7'h00, pauseReq});
    end
    cePrev = ce;
  end

  // Hang guard: the whole table needs well under this many cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    {clock, rst_n, rxDir, cfgWe, cfgMaskWe, tagCount, cfgSa, cfgIdx, cfgMask} = '0;
    {cfgByte, secTci, n_fail, comparisons, cycles, fc} = '0;
    mode = macsec_fmt_pkg::MODE_STD;
    ce   = 1'b1;
    void'($urandom(32'h1591e07d));
    repeat (16) @(posedge clock);
    check("reset outputs", 8'h00, {4'h0, hostReady, lineValid, saHitValid, pauseReq});
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    check("hostReady", 8'h01, {7'h00, hostReady});
    for (int t = 0; t < 14; t++) begin
      run(tm[t], tr[t][0], tt[t], tl[t]);
      $display("test %0d done: mode %0d rx %0d len %0d", t, tm[t], tr[t], tl[t]);
    end
    end_sim();
  end
endmodule : testbench

`default_nettype wire
